/* common/ccfs_consts.svh */
// Constants of the current channel fault selector.
//
// Contract
// - Fault when inputs differ over 6.25% active.
// - After reset the phase input is active.
// - During fault measure on the larger input; the code swaps to it only after a 3 s lead, 2 s after the fault.
// - Fault declared about one second after imbalance.
// - No fault detection below 0.3% voltage.
// - Bit 7 at 0x0F reports active input.
// - Force field 01 phase, 10 neutral, else automatic.
// - Mode clear: flag on fault entry and exit.
// - Flag and enable bit 5 raise interrupt.
// - Smaller inactive input flags, never swaps.
// - Larger neutral input flags and becomes active.
// - Return to phase needs 6.25% lead.
// - Mode set: flag when phase nears neutral.
// - Signed 12-bit trim scales neutral input.
// - Flag independent of load activity.
`ifndef CCFS_CONSTS_SVH
`define CCFS_CONSTS_SVH

// ====================================================================
// Register offsets
`define CCFS_ADDR_ACC_MODE 8'h0F
`define CCFS_ADDR_TRIM 8'h1C
`define CCFS_ADDR_CAL_MODE 8'h3D
`define CCFS_ADDR_IRQ_EN 8'hD9
`define CCFS_ADDR_IRQ_ST 8'hDC

// ====================================================================
// Field positions and codes
`define CCFS_ACC_SEL_BIT 7
`define CCFS_ACC_FMODE_BIT 6
`define CCFS_FLAG_BIT 5
`define CCFS_FORCE_LSB 0
`define CCFS_FORCE_A 2'h1
`define CCFS_FORCE_B 2'h2
`define CCFS_TRIM_FRAC 12

// ====================================================================
// Reset values
`define CCFS_RST_ACC_MODE 8'h00
`define CCFS_RST_CAL_MODE 8'h00
`define CCFS_RST_IRQ_EN 8'h00
`define CCFS_RST_TRIM 12'h000

// ====================================================================
// Thresholds and timing
`define CCFS_REL_SHIFT 4
`define CCFS_V_FULL_SCALE 24'h00_28F5
`define CCFS_V_MIN_PERMILLE 3
`define CCFS_V_MIN (`CCFS_V_FULL_SCALE * `CCFS_V_MIN_PERMILLE / 1000)
`define CCFS_CLK_PERIOD_PS 4000
`define CCFS_TICK_US 1000
`define CCFS_TICK_CYCLES (`CCFS_TICK_US * 1000000 / `CCFS_CLK_PERIOD_PS)
`define CCFS_FAULT_MS 1000
`define CCFS_SWAP_MS 3000
`define CCFS_FAULT_TICKS (`CCFS_FAULT_MS * 1000 / `CCFS_TICK_US)
`define CCFS_SWAP_TICKS (`CCFS_SWAP_MS * 1000 / `CCFS_TICK_US)
`define CCFS_AVG_SHIFT 10

`endif

/* common/ccfs_pkg.sv */
// Types of the current channel fault selector.
package ccfs_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} ccfs_reg_req_t;

	typedef struct packed {
		logic valid;
		logic signed [23:0] ia;
		logic signed [23:0] ib;
		logic signed [23:0] v;
	} ccfs_sample_t;

	typedef enum logic [1:0] {
		CCFS_SEL_A = 2'b01,
		CCFS_SEL_B = 2'b10
	} ccfs_sel_t;

	function automatic logic signed [23:0] ccfs_trim(
		input logic signed [23:0] x,
		input logic signed [11:0] g
	);
		logic signed [35:0] p;
		p = x * g;
		return 24'(x + p[35:12]);
	endfunction

endpackage

/* hdl/ccfs_avg.sv */
// Rectifying leaky averager giving a magnitude estimate.
`timescale 1ns/100ps
module ccfs_avg import ccfs_pkg::*; #(
	parameter int W = 24,
	parameter int SHIFT = 10
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic sample_en,
	input wire logic signed [W-1:0] sample,
	output logic [W-1:0] mag
);

	logic [W+SHIFT-1:0] acc;
	logic [W-1:0] rect;

	// A long time constant rides out brief disturbances on the line.
	assign rect = sample[W-1] ? W'(-sample) : W'(sample);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			acc <= '0;
		end else if (sample_en) begin
			acc <= acc + (W+SHIFT)'(rect) - (W+SHIFT)'(acc >> SHIFT);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mag <= '0;
		end else begin
			mag <= acc[W+SHIFT-1:SHIFT];
		end
	end

endmodule

/* hdl/ccfs_top.sv */
// Current channel fault selector with its metering registers.
`timescale 1ns/100ps
`include "ccfs_consts.svh"
module ccfs_top import ccfs_pkg::*; #(
	parameter int TICK_CYCLES = `CCFS_TICK_CYCLES,
	parameter int FAULT_TICKS = `CCFS_FAULT_TICKS,
	parameter int SWAP_TICKS = `CCFS_SWAP_TICKS,
	parameter int AVG_SHIFT = `CCFS_AVG_SHIFT
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire ccfs_reg_req_t reg_req,
	output logic [15:0] reg_rdata,
	input wire ccfs_sample_t samp,
	output logic signed [23:0] meas_current,
	output logic meas_valid,
	output logic active_input_indicator,
	output logic metering_irq
);

	// ================================================================
	// Registers
	logic [7:0] accumulation_mode;
	logic [7:0] calibration_mode;
	logic [7:0] metering_irq_enable_low;
	logic fault_change;
	logic [11:0] second_input_gain_trim;
	logic [1:0] input_force_select;
	logic fault_mode;

	assign input_force_select =
		calibration_mode[`CCFS_FORCE_LSB+1:`CCFS_FORCE_LSB];
	assign fault_mode = accumulation_mode[`CCFS_ACC_FMODE_BIT];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			accumulation_mode <= `CCFS_RST_ACC_MODE;
			calibration_mode <= `CCFS_RST_CAL_MODE;
			metering_irq_enable_low <= `CCFS_RST_IRQ_EN;
			second_input_gain_trim <= `CCFS_RST_TRIM;
		end else if (reg_req.wr) begin
			unique case (reg_req.addr)
			`CCFS_ADDR_ACC_MODE: begin
				accumulation_mode <= reg_req.wdata[7:0];
			end
			`CCFS_ADDR_CAL_MODE: begin
				calibration_mode <= reg_req.wdata[7:0];
			end
			`CCFS_ADDR_IRQ_EN: begin
				metering_irq_enable_low <= reg_req.wdata[7:0];
			end
			`CCFS_ADDR_TRIM: begin
				second_input_gain_trim <= reg_req.wdata[11:0];
			end
			default: begin
			end
			endcase
		end
	end

	// ================================================================
	// Tick divider
	logic [31:0] tick_cnt;
	logic tick;

	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

	always_ff @(posedge clk_sys) begin
		if (srst || tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end

	// ================================================================
	// Magnitude estimates
	logic [23:0] mag_a;
	logic [23:0] mag_b;
	logic [23:0] mag_v;
	logic signed [23:0] ib_trim;

	assign ib_trim = ccfs_trim(samp.ib, second_input_gain_trim);

	ccfs_avg #(.W(24), .SHIFT(AVG_SHIFT)) u_avg_a (
		.clk_sys(clk_sys),
		.srst(srst),
		.sample_en(samp.valid),
		.sample(samp.ia),
		.mag(mag_a)
	);

	ccfs_avg #(.W(24), .SHIFT(AVG_SHIFT)) u_avg_b (
		.clk_sys(clk_sys),
		.srst(srst),
		.sample_en(samp.valid),
		.sample(ib_trim),
		.mag(mag_b)
	);

	ccfs_avg #(.W(24), .SHIFT(AVG_SHIFT)) u_avg_v (
		.clk_sys(clk_sys),
		.srst(srst),
		.sample_en(samp.valid),
		.sample(samp.v),
		.mag(mag_v)
	);

	// ================================================================
	// Comparisons on averaged magnitudes
	ccfs_sel_t auto_sel;
	logic [23:0] mag_act;
	logic [23:0] diff;
	logic fault_cond;
	logic swap_b;
	logic swap_a;
	logic v_low;
	logic near;
	logic near_q;

	assign mag_act = (auto_sel == CCFS_SEL_B) ? mag_b : mag_a;
	assign diff = (mag_a > mag_b) ? mag_a - mag_b : mag_b - mag_a;
	assign fault_cond = diff > (mag_act >> `CCFS_REL_SHIFT);
	assign swap_b = (mag_b > mag_a) && (diff > (mag_b >> `CCFS_REL_SHIFT));
	assign swap_a = (mag_a > mag_b) && (diff > (mag_b >> `CCFS_REL_SHIFT));
	assign v_low = mag_v < 24'(`CCFS_V_MIN);
	assign near = (auto_sel == CCFS_SEL_B) &&
		(diff <= (mag_b >> `CCFS_REL_SHIFT));

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			near_q <= 1'b0;
		end else begin
			near_q <= near;
		end
	end

	// ================================================================
	// Fault state with one second confirmation
	logic fault_state;
	logic fault_evt;
	logic [15:0] fault_cnt;

	// Both entry and exit need a steady condition, so with fault_mode clear a glitch flags nothing.
	assign fault_evt = tick && !v_low && (fault_cond != fault_state) &&
		(fault_cnt == 16'(FAULT_TICKS - 1));

	always_ff @(posedge clk_sys) begin
		if (srst || v_low) begin
			fault_cnt <= '0;
		end else if (tick) begin
			if (fault_cond == fault_state || fault_evt) begin
				fault_cnt <= '0;
			end else begin
				fault_cnt <= fault_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			fault_state <= 1'b0;
		end else if (fault_evt) begin
			fault_state <= !fault_state;
		end
	end

	// ================================================================
	// Automatic selection with hysteresis
	logic swap_cond;
	logic swap_evt;
	logic [15:0] swap_cnt;

	always_comb begin
		unique case (auto_sel)
		CCFS_SEL_A: swap_cond = swap_b;
		CCFS_SEL_B: swap_cond = swap_a;
		default: swap_cond = 1'b0;
		endcase
	end

	assign swap_evt = tick && !v_low && swap_cond &&
		(swap_cnt == 16'(SWAP_TICKS - 1));

	always_ff @(posedge clk_sys) begin
		if (srst || v_low) begin
			swap_cnt <= '0;
		end else if (tick) begin
			if (!swap_cond || swap_evt) begin
				swap_cnt <= '0;
			end else begin
				swap_cnt <= swap_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			auto_sel <= CCFS_SEL_A;
		end else if (swap_evt) begin
			auto_sel <= (auto_sel == CCFS_SEL_A) ? CCFS_SEL_B : CCFS_SEL_A;
		end
	end

	// ================================================================
	// Active input, measurement path and indicator
	logic next_sel;

	always_comb begin
		unique case (input_force_select)
		`CCFS_FORCE_A: next_sel = 1'b0;
		`CCFS_FORCE_B: next_sel = 1'b1;
		default: next_sel = (auto_sel == CCFS_SEL_B);
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			active_input_indicator <= 1'b0;
		end else begin
			active_input_indicator <= next_sel;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meas_current <= '0;
			meas_valid <= 1'b0;
		end else begin
			meas_valid <= samp.valid;
			if (samp.valid) begin
				meas_current <= active_input_indicator ? ib_trim : samp.ia;
			end
		end
	end

	// ================================================================
	// Fault change flag and interrupt
	logic flag_set;
	logic flag_clr;

	assign flag_set = fault_mode ? (near && !near_q) : fault_evt;
	assign flag_clr = reg_req.wr && (reg_req.addr == `CCFS_ADDR_IRQ_ST) &&
		!reg_req.wdata[`CCFS_FLAG_BIT];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			fault_change <= 1'b0;
		end else if (flag_set) begin
			fault_change <= 1'b1;
		end else if (flag_clr) begin
			fault_change <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			metering_irq <= 1'b0;
		end else begin
			metering_irq <= fault_change &&
				metering_irq_enable_low[`CCFS_FLAG_BIT];
		end
	end

	// ================================================================
	// Read port
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reg_rdata <= '0;
		end else if (reg_req.rd) begin
			unique case (reg_req.addr)
			`CCFS_ADDR_ACC_MODE: begin
				reg_rdata <= {8'h00, active_input_indicator,
					accumulation_mode[6:0]};
			end
			`CCFS_ADDR_CAL_MODE: reg_rdata <= {8'h00, calibration_mode};
			`CCFS_ADDR_IRQ_EN: reg_rdata <= {8'h00, metering_irq_enable_low};
			`CCFS_ADDR_IRQ_ST: reg_rdata <= {10'h000, fault_change, 5'h00};
			`CCFS_ADDR_TRIM: reg_rdata <= {4'h0, second_input_gain_trim};
			default: reg_rdata <= '0;
			endcase
		end
	end

	// ================================================================
	// Assertions
	sequence s_near_rise;
		!near ##1 (near && fault_mode);
	endsequence

	property p_force_a;
		@(posedge clk_sys) disable iff (srst)
		input_force_select == `CCFS_FORCE_A |=> !active_input_indicator;
	endproperty
	a_force_a: assert property (p_force_a) else $error("force A ignored");

	property p_force_b;
		@(posedge clk_sys) disable iff (srst)
		input_force_select == `CCFS_FORCE_B |=> active_input_indicator;
	endproperty
	a_force_b: assert property (p_force_b) else $error("force B ignored");

	property p_sel_read;
		@(posedge clk_sys) disable iff (srst)
		reg_req.rd && reg_req.addr == `CCFS_ADDR_ACC_MODE |=>
			reg_rdata[7] == $past(active_input_indicator);
	endproperty
	a_sel_read: assert property (p_sel_read) else $error("bad bit 7");

	property p_irq;
		@(posedge clk_sys) disable iff (srst)
		fault_change && metering_irq_enable_low[5] |=> metering_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");

	property p_fault_flag;
		@(posedge clk_sys) disable iff (srst)
		fault_evt && !fault_mode |=> fault_change && $changed(fault_state);
	endproperty
	a_fault_flag: assert property (p_fault_flag) else $error("no flag");

	property p_near_flag;
		@(posedge clk_sys) disable iff (srst)
		s_near_rise |=> fault_change;
	endproperty
	a_near_flag: assert property (p_near_flag) else $error("no near flag");

	property p_vlow;
		@(posedge clk_sys) disable iff (srst)
		v_low |=> fault_cnt == 16'h0000 && $stable(fault_state);
	endproperty
	a_vlow: assert property (p_vlow) else $error("detect not inhibited");

	property p_reset_sel;
		@(posedge clk_sys) srst |=> auto_sel == CCFS_SEL_A;
	endproperty
	a_reset_sel: assert property (p_reset_sel) else $error("not phase");

	property p_swap_b;
		@(posedge clk_sys) disable iff (srst)
		swap_evt && auto_sel == CCFS_SEL_A |=> auto_sel == CCFS_SEL_B;
	endproperty
	a_swap_b: assert property (p_swap_b) else $error("swap missed");

	property p_hold_b;
		@(posedge clk_sys) disable iff (srst)
		auto_sel == CCFS_SEL_B && !swap_a |=> auto_sel == CCFS_SEL_B;
	endproperty
	a_hold_b: assert property (p_hold_b) else $error("chatter");

	property p_trim;
		@(posedge clk_sys) disable iff (srst)
		samp.valid && active_input_indicator |=>
			meas_current == $past(ib_trim);
	endproperty
	a_trim: assert property (p_trim) else $error("trim not applied");

endmodule

/* verif/ccfs_src_model.sv */
// Sample source model standing in for the metering converters.
`timescale 1ns/100ps
module ccfs_src_model import ccfs_pkg::*; (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic signed [23:0] amp_a,
	input wire logic signed [23:0] amp_b,
	input wire logic signed [23:0] amp_v,
	output ccfs_sample_t samp
);
	// ==========================================================
	// Sample stream
	// Between strobes the data carries the inverse, so a design that
	// samples off the strobe picks up a visibly wrong value.
	logic ph;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ph <= 1'b0;
			samp <= '0;
		end else begin
			ph <= ~ph;
			samp.valid <= ~ph;
			samp.ia <= ph ? ~amp_a : amp_a;
			samp.ib <= ph ? ~amp_b : amp_b;
			samp.v <= ph ? ~amp_v : amp_v;
		end
	end
endmodule

/* verif/testbench.sv */
// Self-checking testbench of the current channel fault selector.
`timescale 1ns/100ps
module testbench import ccfs_pkg::*;;
	// ==========================================================
	// Clock, reset and stimulus state
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	ccfs_reg_req_t reg_req = '0;
	ccfs_sample_t samp;
	logic [15:0] reg_rdata;
	logic signed [23:0] meas_current, a = 1000, b = 1000, v = 2000;
	logic signed [23:0] meas_exp;
	logic meas_valid, active_input_indicator, metering_irq;
	logic meas_on = 1'b0, rd_d1 = 1'b0, rd_d2 = 1'b0;
	logic [15:0] rq[$], st = 16'h0047;
	logic [11:0] g;
	int err_total = 0, n_checks = 0, cyc_cnt = 0, tn = 0;
	always #2 clk_sys = ~clk_sys;
	// Short counts keep every decision within a few hundred cycles.
	ccfs_top #(.TICK_CYCLES(4), .FAULT_TICKS(3), .SWAP_TICKS(5),
		.AVG_SHIFT(2)) DUT (.clk_sys(clk_sys), .srst(srst),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .samp(samp),
		.meas_current(meas_current), .meas_valid(meas_valid),
		.active_input_indicator(active_input_indicator),
		.metering_irq(metering_irq));
	ccfs_src_model src (.clk_sys(clk_sys), .srst(srst), .amp_a(a),
		.amp_b(b), .amp_v(v), .samp(samp));
	// ==========================================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [23:0] trimmed(input logic signed [23:0] x,
		input logic signed [11:0] k);
		logic signed [35:0] p;
		p = x * k;
		return x + p[35:12];
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [15:0] d);
		@(negedge clk_sys);
		reg_req.wr = 1'b1;
		reg_req.addr = ad;
		reg_req.wdata = d;
		@(negedge clk_sys);
		reg_req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [15:0] exp);
		rq.push_back(exp);
		@(negedge clk_sys);
		reg_req.rd = 1'b1;
		reg_req.addr = ad;
		@(negedge clk_sys);
		reg_req.rd = 1'b0;
	endtask
	task automatic tdone();
		tn++;
		$display("test %0d done", tn);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ==========================================================
	// Result watcher
	always @(posedge clk_sys) begin
		rd_d1 <= reg_req.rd;
		rd_d2 <= rd_d1;
		cyc_cnt++;
		if (cyc_cnt == 10000) begin
			err_total++;
			end_sim();
		end
	end
	always @(negedge clk_sys) begin
		if (rd_d2 && rq.size() > 0)
			check(reg_rdata, rq.pop_front());
		if (meas_on && meas_valid)
			check(meas_current, meas_exp);
	end
	// ==========================================================
	// Scenarios
	initial begin
		cyc(6);
		srst = 1'b0;
		check(active_input_indicator, 0);
		wr(8'h55, 16'hFFFF);
		rd(8'h0F, 16'h0000);
		rd(8'h1C, 16'h0000);
		rd(8'h3D, 16'h0000);
		rd(8'hD9, 16'h0000);
		rd(8'hDC, 16'h0000);
		rd(8'h55, 16'h0000);
		tdone();
		st = lfsr(st);
		g = {6'h00, st[5:0]};
		st = lfsr(st);
		b = 24'sd1000 + st[4:0];
		wr(8'h1C, {4'h0, g});
		rd(8'h1C, {4'h0, g});
		cyc(200);
		for (int f = 0; f < 4; f++) begin
			wr(8'h3D, 16'(f));
			cyc(4);
			check(active_input_indicator, f == 2);
			rd(8'h0F, (f == 2) ? 16'h0080 : 16'h0000);
			meas_exp = (f == 2) ? trimmed(b, g) : a;
			meas_on = 1'b1;
			cyc(8);
			meas_on = 1'b0;
		end
		wr(8'h3D, 16'h0000);
		wr(8'h1C, 16'h0000);
		tdone();
		wr(8'hD9, 16'h0020);
		rd(8'hD9, 16'h0020);
		b = 500;
		cyc(4);
		check(metering_irq, 0);
		cyc(300);
		check(active_input_indicator, 0);
		check(metering_irq, 1);
		rd(8'hDC, 16'h0020);
		wr(8'hD9, 16'h0000);
		cyc(2);
		check(metering_irq, 0);
		wr(8'hD9, 16'h0020);
		wr(8'hDC, 16'h0020);
		rd(8'hDC, 16'h0020);
		wr(8'hDC, 16'h0000);
		cyc(2);
		check(metering_irq, 0);
		rd(8'hDC, 16'h0000);
		tdone();
		b = 2000;
		cyc(300);
		check(active_input_indicator, 1);
		rd(8'h0F, 16'h0080);
		meas_exp = 2000;
		meas_on = 1'b1;
		cyc(8);
		meas_on = 1'b0;
		a = 2100;
		cyc(300);
		check(active_input_indicator, 1);
		a = 2200;
		cyc(300);
		check(active_input_indicator, 0);
		tdone();
		wr(8'h0F, 16'h0040);
		rd(8'h0F, 16'h0040);
		b = 2400;
		cyc(300);
		check(active_input_indicator, 1);
		wr(8'hDC, 16'h0000);
		rd(8'hDC, 16'h0000);
		a = 2350;
		cyc(300);
		rd(8'hDC, 16'h0020);
		tdone();
		wr(8'h0F, 16'h0000);
		// The voltage estimate must settle below its floor first, or the
		// swap back to phase completes before detection is inhibited.
		v = 10;
		cyc(100);
		wr(8'hDC, 16'h0000);
		b = 1000;
		cyc(300);
		check(active_input_indicator, 1);
		rd(8'hDC, 16'h0000);
		v = 2000;
		cyc(300);
		check(active_input_indicator, 0);
		tdone();
		cyc(4);
		end_sim();
	end
endmodule
